// >>> common/dsp_ddr_if.sv
/*
  Link between memory controller and DDR memory.
  Data pins carry one clock of data as a pair: [15:0] rising half,
  [31:16] falling half; strobe pairs likewise in bits [0] and [1].
*/
`timescale 1ns/1ns
`default_nettype none
interface dsp_ddr_if;
  logic        ck;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  ba;
  logic [12:0] a;
  logic [31:0] dq_c_o;
  logic        dq_c_oe;
  logic [1:0]  dqs_c_o;
  logic        dqs_c_oe;
  logic [31:0] dq_d_o;
  logic [1:0]  dq_d_oe;
  logic [1:0]  dqs_d_o;
  logic [1:0]  dqs_d_oe;
  logic [31:0] dq;
  logic [1:0]  dqs;

  // wire level from the enables; undriven reads low
  assign dq  = dq_c_oe ? dq_c_o : {dq_d_oe[1] ? dq_d_o[31:16] : 16'h0000,
                                   dq_d_oe[0] ? dq_d_o[15:0] : 16'h0000};
  assign dqs = dqs_c_oe ? dqs_c_o : (dqs_d_o & dqs_d_oe);

  modport ctl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, a,
               output dq_c_o, dq_c_oe, dqs_c_o, dqs_c_oe,
               input dq_d_o, dq_d_oe, dq, dqs);
  modport dev (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, a, dq, dqs,
               input dq_c_oe, dqs_c_oe,
               output dq_d_o, dq_d_oe, dqs_d_o, dqs_d_oe);
endinterface : dsp_ddr_if
`default_nettype wire

// >>> common/dsp_pkg.sv
/*
  Shared constants for the DDR link: command codes, mode register layout,
  timing counts and the burst address order function.
  Assumes the link clock runs at half of CLK_IN (8 ns).
*/
`default_nettype none
package dsp_pkg;
  // link clock period and timing figures
  localparam int T_CK_NS    = 8;
  localparam int T_PWRUP_US = 200;
  localparam int PWRUP_CK   = T_PWRUP_US * 1000 / T_CK_NS;
  localparam int T_RP_NS    = 15;
  localparam int T_RCD_NS   = 15;
  localparam int T_RFC_NS   = 70;
  localparam int T_MRD_NS   = 10;
  localparam int T_WR_NS    = 15;
  localparam int T_REFI_NS  = 7800;
  localparam int RP_CK      = (T_RP_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int RCD_CK     = (T_RCD_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int RFC_CK     = (T_RFC_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int MRD_CK     = (T_MRD_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int WR_CK      = (T_WR_NS + T_CK_NS - 1) / T_CK_NS;
  localparam int REFI_CK    = T_REFI_NS / T_CK_NS;
  localparam int DLL_LOCK_CK = 200;
  localparam int XSRD_CK    = 200;
  localparam logic [3:0] REF_POST_MAX = 4'h8;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_BST = 4'h6;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_AR  = 4'h1;
  localparam logic [3:0] C_MRS = 4'h0;
  // mode register layout
  localparam int MR_BL_LSB  = 0;
  localparam int MR_BT_BIT  = 3;
  localparam int MR_CL_LSB  = 4;
  localparam int MR_DLL_BIT = 8;
  localparam int A_AP_BIT   = 10;
  localparam logic [2:0] BL2_CODE = 3'h1;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CL2_CODE = 3'h2;
  localparam logic [2:0] CL25_CODE = 3'h6;
  localparam logic [2:0] CL3_CODE = 3'h3;
  localparam logic [1:0]  BA_MR    = 2'h0;
  localparam logic [1:0]  BA_EMR   = 2'h1;
  localparam logic [12:0] MR_RESET = 13'h0022;
  localparam logic [12:0] EMR_DLL_ON = 13'h0000;
  localparam logic [12:0] MR_DLLRST = 13'h0132;
  localparam logic [12:0] MR_FINAL = 13'h0032;
  localparam int CTRL_HALF_BL = 2;

  // column of element i of a burst of n starting at base
  function automatic logic [2:0] bidx(input logic [2:0] base, input logic [3:0] i,
                                      input logic [3:0] n, input logic inter);
    logic [2:0] m;
    m = 3'(n - 4'h1);
    if (inter)
      bidx = (base & ~m) | ((base ^ i[2:0]) & m);
    else
      bidx = (base & ~m) | (3'(base + i[2:0]) & m);
  endfunction : bidx
endpackage : dsp_pkg
`default_nettype wire

// >>> hdl/dsp_ddr_ctl.sv
/*
  Controller end: makes the link clock, runs the power-up sequence, then
  serves single bursts of four (activate, read or write, precharge) and
  keeps refresh and self refresh.
  Assumes the memory end samples on the rising link clock.
*/
// Behaviour
// RQ1 - refresh uses internal row counter
// RQ2 - output enable follows data timing windows
// RQ3 - write strobe valid before first reference
// RQ4 - write preamble from high-Z to low
// RQ5 - long write postamble is harmless
// RQ6 - at most eight refreshes posted
// RQ7 - no-op and clock enable low at power
// RQ8 - stable clock 200 us first
// RQ9 - no-op with clock enable high, precharge all
// RQ10 - extended mode DLL on, then DLL reset
// RQ11 - 200 clocks DLL lock before reads
// RQ12 - precharge all then two refreshes
// RQ13 - final mode load with A8 low
// RQ14 - first data after CAS latency, ordered
// RQ15 - back-to-back reads concatenate or cut
// RQ16 - random reads interrupt previous burst
// RQ17 - burst terminate cuts eight to four
// RQ18 - terminate read before a write
// RQ19 - precharge no earlier than half burst
// RQ20 - all banks idle before self refresh
// RQ21 - read strobe edge aligned, one-clock preamble
`timescale 1ns/1ns
`default_nettype none
module dsp_ddr_ctl
  import dsp_pkg::*;
#(
  parameter int PWRUP_CYC = PWRUP_CK
)
(
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  // request
  input  wire logic        RD_REQ_IN,
  input  wire logic        WR_REQ_IN,
  input  wire logic [1:0]  BANK_IN,
  input  wire logic [12:0] ROW_IN,
  input  wire logic [9:0]  COL_IN,
  input  wire logic [63:0] WDATA_IN,
  input  wire logic        SREF_IN,
  output logic             READY_OUT,
  output logic             INIT_DONE_OUT,
  // read data
  output logic      [31:0] RDATA_OUT,
  output logic      [1:0]  RVALID_OUT,
  // link
  dsp_ddr_if.ctl           LNK
);
  typedef enum logic [4:0] {
    ST_PWR  = 5'h00, ST_CKE  = 5'h01, ST_PREA1 = 5'h02, ST_EMRS = 5'h03,
    ST_MRSR = 5'h04, ST_PREA2 = 5'h05, ST_AR1 = 5'h06, ST_AR2 = 5'h07,
    ST_MRSF = 5'h08, ST_DLL  = 5'h09, ST_IDLE = 5'h0a, ST_ACT = 5'h0b,
    ST_RD   = 5'h0c, ST_BST  = 5'h0d, ST_WR  = 5'h0e, ST_WD = 5'h0f,
    ST_WP   = 5'h10, ST_WRC  = 5'h11, ST_PRE = 5'h12, ST_REF = 5'h13,
    ST_SREF = 5'h14
  } dsp_st_t;

  dsp_st_t     st_q;
  logic        ck_q;
  logic        tick;
  logic [15:0] wait_q;
  logic [7:0]  dll_q;
  logic        dll_run_q;
  logic [9:0]  refi_q;
  logic        due;
  logic [3:0]  post_q;
  logic        ref_go;
  logic        req_q;
  logic        req_wr_q;
  logic [1:0]  ba_q;
  logic [12:0] row_q;
  logic [9:0]  col_q;
  logic [63:0] wdat_q;
  logic        wbeat_q;
  logic [31:0] dq_s1_q;
  logic [31:0] dq_s2_q;
  logic [1:0]  oe_s1_q;
  logic [1:0]  oe_s2_q;

  // commands change on the falling link clock
  assign tick = ck_q;
  assign ref_go = tick && wait_q == 16'h0000 && st_q == ST_REF;
  assign due = refi_q == 10'(REFI_CK - 1);
  assign LNK.ck = ck_q;

  //////////////////////////////////////////////////////////////////////
  // link clock divider
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      ck_q <= 1'b0;
    else
      ck_q <= ~ck_q;
  end

  //////////////////////////////////////////////////////////////////////
  // refresh interval and posted count
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      refi_q <= 10'h000;
      post_q <= 4'h0;
    end
    else
    begin
      if (tick)
        refi_q <= due ? 10'h000 : 10'(refi_q + 10'h001);
      if (tick && due && INIT_DONE_OUT && !ref_go && st_q != ST_SREF)
        post_q <= 4'(post_q + 4'h1);
      else if (ref_go && !(tick && due))
        post_q <= 4'(post_q - 4'h1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // DLL lock wait
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
      dll_q <= 8'h00;
    else if (tick && dll_run_q && dll_q != 8'(DLL_LOCK_CK))
      dll_q <= 8'(dll_q + 8'h01); // RQ11
  end

  //////////////////////////////////////////////////////////////////////
  // read data return, two-stage synchroniser
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      dq_s1_q <= 32'h0000_0000;
      dq_s2_q <= 32'h0000_0000;
      oe_s1_q <= 2'h0;
      oe_s2_q <= 2'h0;
      RDATA_OUT <= 32'h0000_0000;
      RVALID_OUT <= 2'h0;
    end
    else
    begin
      dq_s1_q <= LNK.dq_d_o;
      dq_s2_q <= dq_s1_q;
      oe_s1_q <= LNK.dq_d_oe;
      oe_s2_q <= oe_s1_q;
      RVALID_OUT <= tick ? oe_s2_q : 2'h0;
      if (tick)
        RDATA_OUT <= dq_s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      st_q <= ST_PWR;
      wait_q <= 16'(PWRUP_CYC); // RQ8
      LNK.cke <= 1'b0; // RQ7
      {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_NOP; // RQ7
      LNK.ba <= 2'h0;
      LNK.a <= 13'h0000;
      LNK.dq_c_o <= 32'h0000_0000;
      LNK.dq_c_oe <= 1'b0;
      LNK.dqs_c_o <= 2'h0;
      LNK.dqs_c_oe <= 1'b0;
      dll_run_q <= 1'b0;
      INIT_DONE_OUT <= 1'b0;
      READY_OUT <= 1'b0;
      req_q <= 1'b0;
      req_wr_q <= 1'b0;
      ba_q <= 2'h0;
      row_q <= 13'h0000;
      col_q <= 10'h000;
      wdat_q <= 64'h0;
      wbeat_q <= 1'b0;
    end
    else
    begin
      if (READY_OUT && (RD_REQ_IN || WR_REQ_IN))
      begin
        READY_OUT <= 1'b0;
        req_q <= 1'b1;
        req_wr_q <= WR_REQ_IN;
        ba_q <= BANK_IN;
        row_q <= ROW_IN;
        col_q <= COL_IN;
        wdat_q <= WDATA_IN;
      end
      if (tick)
      begin
        {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_NOP;
        if (wait_q != 16'h0000)
          wait_q <= 16'(wait_q - 16'h0001);
        else
          case (st_q)
            ST_PWR:
              st_q <= ST_CKE;
            ST_CKE:
            begin
              LNK.cke <= 1'b1; // RQ9
              st_q <= ST_PREA1;
            end
            ST_PREA1, ST_PREA2, ST_PRE:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_PRE; // RQ9 RQ12
              LNK.a <= 13'h0000;
              LNK.a[A_AP_BIT] <= 1'b1;
              LNK.dqs_c_oe <= 1'b0;
              wait_q <= 16'(RP_CK - 1);
              st_q <= (st_q == ST_PREA1) ? ST_EMRS : (st_q == ST_PREA2) ? ST_AR1 : ST_IDLE;
              if (st_q == ST_PRE)
              begin
                req_q <= 1'b0;
                READY_OUT <= 1'b1;
              end
            end
            ST_EMRS, ST_MRSR, ST_MRSF:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_MRS;
              LNK.ba <= (st_q == ST_EMRS) ? BA_EMR : BA_MR;
              LNK.a <= (st_q == ST_EMRS) ? EMR_DLL_ON : (st_q == ST_MRSR) ? MR_DLLRST : MR_FINAL; // RQ10 RQ13
              dll_run_q <= dll_run_q || st_q == ST_MRSR;
              wait_q <= 16'(MRD_CK - 1);
              st_q <= (st_q == ST_EMRS) ? ST_MRSR : (st_q == ST_MRSR) ? ST_PREA2 : ST_DLL;
            end
            ST_AR1, ST_AR2:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_AR; // RQ12
              wait_q <= 16'(RFC_CK - 1);
              st_q <= (st_q == ST_AR1) ? ST_AR2 : ST_MRSF;
            end
            ST_DLL:
              if (dll_q == 8'(DLL_LOCK_CK))
              begin
                INIT_DONE_OUT <= 1'b1; // RQ11
                READY_OUT <= 1'b1;
                st_q <= ST_IDLE;
              end
            ST_IDLE:
              if (post_q != 4'h0 && (post_q >= REF_POST_MAX || !req_q))
                st_q <= ST_REF; // RQ6
              else if (req_q)
                st_q <= ST_ACT;
              else if (SREF_IN)
              begin
                {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_AR; // RQ20
                LNK.cke <= 1'b0;
                st_q <= ST_SREF;
              end
            ST_REF:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_AR;
              wait_q <= 16'(RFC_CK - 1);
              st_q <= ST_IDLE;
            end
            ST_SREF:
              if (!SREF_IN)
              begin
                LNK.cke <= 1'b1;
                wait_q <= 16'(XSRD_CK - 1);
                st_q <= ST_IDLE;
              end
            ST_ACT:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_ACT;
              LNK.ba <= ba_q;
              LNK.a <= row_q;
              wait_q <= 16'(RCD_CK - 1);
              st_q <= req_wr_q ? ST_WR : ST_RD;
            end
            ST_RD:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_RD;
              LNK.a <= {3'h0, col_q};
              wait_q <= 16'(CTRL_HALF_BL - 1);
              st_q <= ST_BST;
            end
            ST_BST:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_BST; // RQ18 RQ19
              st_q <= ST_PRE;
            end
            ST_WR:
            begin
              {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} <= C_WR;
              LNK.a <= {3'h0, col_q};
              LNK.dqs_c_o <= 2'h0; // RQ4
              LNK.dqs_c_oe <= 1'b1; // RQ3
              wbeat_q <= 1'b0;
              st_q <= ST_WD;
            end
            ST_WD:
            begin
              LNK.dq_c_o <= wbeat_q ? wdat_q[63:32] : wdat_q[31:0];
              LNK.dq_c_oe <= 1'b1;
              LNK.dqs_c_o <= 2'h1;
              wbeat_q <= 1'b1;
              if (wbeat_q)
                st_q <= ST_WP;
            end
            ST_WP:
            begin
              LNK.dq_c_oe <= 1'b0;
              LNK.dqs_c_o <= 2'h0;
              wait_q <= 16'(WR_CK - 1);
              st_q <= ST_WRC;
            end
            default:
              st_q <= ST_PRE;
          endcase
      end
    end
  end
endmodule : dsp_ddr_ctl
`default_nettype wire

// >>> hdl/dsp_ddr_dev.sv
/*
  Memory end: mode register, refresh row counter, read burst engine with
  CAS latency 2, 2.5 or 3, and write capture into a small array.
  Assumes it is clocked by the link clock and commands are stable at its rise.
*/
`timescale 1ns/1ns
`default_nettype none
module dsp_ddr_dev
  import dsp_pkg::*;
(
  // reset
  input  wire logic        NRST_IN,
  // link
  dsp_ddr_if.dev           LNK,
  // status
  output logic      [12:0] MODE_OUT,
  output logic      [12:0] REF_ROW_OUT
);
  logic [3:0]  cmd;
  logic [2:0]  rd_dl_q;
  logic [2:0]  bst_dl_q;
  logic [2:0]  col_dl_q [0:2];
  logic [15:0] mem_q [0:7];
  logic        act_q;
  logic [3:0]  i_q;
  logic [2:0]  base_q;
  logic [3:0]  n_q;
  logic [3:0]  bl;
  logic        inter;
  logic        cl3;
  logic        hoff;
  logic        tap_rd;
  logic        tap_bst;
  logic [2:0]  tap_col;
  logic        la_rd;
  logic        act_d;
  logic [3:0]  i_d;
  logic [2:0]  base_d;
  logic [3:0]  n_d;
  logic [31:0] dq_d;
  logic [1:0]  dqoe_d;
  logic [1:0]  dqs_d;
  logic [1:0]  dqsoe_d;
  logic [2:0]  wr_left_q;
  logic [3:0]  wr_i_q;
  logic [2:0]  wr_col_q;

  assign cmd = LNK.cke ? {LNK.cs_n, LNK.ras_n, LNK.cas_n, LNK.we_n} : C_NOP;
  assign bl = (MODE_OUT[MR_BL_LSB+:3] == BL2_CODE) ? 4'h2 :
              (MODE_OUT[MR_BL_LSB+:3] == BL8_CODE) ? 4'h8 : 4'h4;
  assign inter = MODE_OUT[MR_BT_BIT];
  assign cl3 = MODE_OUT[MR_CL_LSB+:3] == CL3_CODE;
  assign hoff = MODE_OUT[MR_CL_LSB+:3] == CL25_CODE;
  assign tap_rd = cl3 ? rd_dl_q[2] : rd_dl_q[1];
  assign tap_bst = cl3 ? bst_dl_q[2] : bst_dl_q[1];
  assign tap_col = cl3 ? col_dl_q[2] : col_dl_q[1];
  assign la_rd = cl3 ? rd_dl_q[1] : rd_dl_q[0];

  //////////////////////////////////////////////////////////////////////
  // mode register and refresh counter
  always_ff @(posedge LNK.ck or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      MODE_OUT <= MR_RESET;
      REF_ROW_OUT <= 13'h0000;
    end
    else if (cmd == C_MRS && LNK.ba == BA_MR)
      MODE_OUT <= LNK.a;
    else if (cmd == C_AR)
      REF_ROW_OUT <= 13'(REF_ROW_OUT + 13'h0001); // RQ1
  end

  //////////////////////////////////////////////////////////////////////
  // command delay line for the read latency
  always_ff @(posedge LNK.ck or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      rd_dl_q <= 3'h0;
      bst_dl_q <= 3'h0;
      for (int k = 0; k < 3; k++)
        col_dl_q[k] <= 3'h0;
    end
    else
    begin
      rd_dl_q <= {rd_dl_q[1:0], cmd == C_RD};
      bst_dl_q <= {bst_dl_q[1:0], cmd == C_BST};
      col_dl_q[0] <= LNK.a[2:0];
      col_dl_q[1] <= col_dl_q[0];
      col_dl_q[2] <= col_dl_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read burst engine, two half-clock slots per clock
  always_comb
  begin
    act_d = act_q;
    i_d = i_q;
    base_d = base_q;
    n_d = n_q;
    dq_d = 32'h0000_0000;
    dqoe_d = 2'h0;
    dqs_d = 2'h0;
    dqsoe_d = 2'h0;
    for (int h = 0; h < 2; h++)
    begin
      if (h == int'(hoff) && tap_rd)
      begin
        act_d = 1'b1; // RQ15 RQ16
        i_d = 4'h0;
        base_d = tap_col;
        n_d = bl;
      end
      if (h == int'(hoff) && tap_bst)
        act_d = 1'b0; // RQ17
      if (act_d)
      begin
        dq_d[h*16+:16] = mem_q[bidx(base_d, i_d, n_d, inter)]; // RQ14
        dqoe_d[h] = 1'b1; // RQ2
        dqsoe_d[h] = 1'b1;
        dqs_d[h] = ~i_d[0]; // RQ21
        i_d = 4'(i_d + 4'h1);
        if (i_d == n_d)
          act_d = 1'b0;
      end
      else if ((la_rd && (!hoff || h == 1)) || (tap_rd && hoff && h == 0))
        dqsoe_d[h] = 1'b1; // RQ21
    end
  end

  always_ff @(posedge LNK.ck or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      act_q <= 1'b0;
      i_q <= 4'h0;
      base_q <= 3'h0;
      n_q <= 4'h4;
      LNK.dq_d_o <= 32'h0000_0000;
      LNK.dq_d_oe <= 2'h0;
      LNK.dqs_d_o <= 2'h0;
      LNK.dqs_d_oe <= 2'h0;
    end
    else
    begin
      act_q <= act_d;
      i_q <= i_d;
      base_q <= base_d;
      n_q <= n_d;
      LNK.dq_d_o <= dq_d; // RQ2
      LNK.dq_d_oe <= dqoe_d;
      LNK.dqs_d_o <= dqs_d;
      LNK.dqs_d_oe <= dqsoe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // write capture; strobe is not watched after the last pair
  always_ff @(posedge LNK.ck or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      wr_left_q <= 3'h0;
      wr_i_q <= 4'h0;
      wr_col_q <= 3'h0;
      for (int k = 0; k < 8; k++)
        mem_q[k] <= 16'h0000;
    end
    else if (cmd == C_WR)
    begin
      wr_left_q <= bl[3:1];
      wr_i_q <= 4'h0;
      wr_col_q <= LNK.a[2:0];
    end
    else if (wr_left_q != 3'h0)
    begin
      mem_q[bidx(wr_col_q, wr_i_q, bl, inter)] <= LNK.dq[15:0];
      mem_q[bidx(wr_col_q, 4'(wr_i_q + 4'h1), bl, inter)] <= LNK.dq[31:16];
      wr_i_q <= 4'(wr_i_q + 4'h2);
      wr_left_q <= 3'(wr_left_q - 3'h1); // RQ5
    end
  end
endmodule : dsp_ddr_dev
`default_nettype wire

// >>> tb/dsp_ddr_props.sv
/*
  Link checker: command order, read and write strobe and data slots.
  Assumes BL4, CL3 after init and a single clock domain, the link clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dsp_ddr_props
  import dsp_pkg::*;
(
  // clock and reset
  input wire logic        ck,
  input wire logic        NRST_IN,
  // command
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  ba,
  input wire logic [12:0] a,
  // data and strobe enables
  input wire logic        dq_c_oe,
  input wire logic [1:0]  dqs_c_o,
  input wire logic        dqs_c_oe,
  input wire logic [1:0]  dq_d_oe,
  input wire logic [1:0]  dqs_d_o,
  input wire logic [1:0]  dqs_d_oe
);
  localparam int POST_LIM = 9 * REFI_CK;
  logic [3:0]  cmd;
  logic [15:0] lock_q;
  logic [15:0] gap_q;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  default clocking cb @(posedge ck); endclocking
  default disable iff (!NRST_IN);
  ////////////////////////////////////////
  // clocks since the dll reset load
  always_ff @(posedge ck or negedge NRST_IN)
    if (!NRST_IN) lock_q <= '0;
    else if (cke && cmd == C_MRS && ba == BA_MR && a[MR_DLL_BIT]) lock_q <= 16'h0001;
    else if (lock_q != '0 && lock_q != 16'hffff) lock_q <= lock_q + 16'h0001;
  // clocks since the last refresh, paused in self refresh
  always_ff @(posedge ck or negedge NRST_IN)
    if (!NRST_IN) gap_q <= '0;
    else if (cke && cmd == C_AR) gap_q <= 16'h0001;
    else if (cke && gap_q != '0 && gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
  ////////////////////////////////////////
  sequence s_rpre; dqs_d_oe == 2'b11 && dqs_d_o == 2'b00 && dq_d_oe == 2'b00; endsequence
  sequence s_rdat; dq_d_oe == 2'b11 && dqs_d_oe == 2'b11 && dqs_d_o == 2'b01; endsequence
  sequence s_wpre; dqs_c_oe && dqs_c_o == 2'b00 && !$past(dqs_c_oe); endsequence
  sequence s_wdat; dq_c_oe && dqs_c_oe && dqs_c_o == 2'b01; endsequence
  property p_rd_lat; cke && cmd == C_RD |-> ##3 s_rpre ##1 s_rdat ##1 s_rdat; endproperty
  property p_bst; cke && cmd == C_BST |-> ##4 dq_d_oe == 2'b00; endproperty
  property p_oe; dq_d_oe != 2'b00 |-> dqs_d_oe == dq_d_oe; endproperty
  property p_cke_nop; $rose(cke) |-> cmd == C_NOP; endproperty
  property p_emr; cke && cmd == C_MRS && ba == BA_EMR |-> a[0] == 1'b0; endproperty
  property p_lock; cke && cmd == C_RD |-> lock_q >= DLL_LOCK_CK; endproperty
  property p_rd_pre; cke && cmd == C_RD |=> !(cke && cmd == C_PRE); endproperty
  property p_wr; cke && cmd == C_WR |-> s_wpre ##1 s_wdat; endproperty
  property p_post; gap_q <= POST_LIM; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read strobe or data off its slot");
  a_bst: assert property (p_bst)
    else $error("read data still driven after burst stop");
  a_oe: assert property (p_oe)
    else $error("data enable without matching strobe enable");
  a_cke_nop: assert property (p_cke_nop)
    else $error("clock enable raised without no-op");
  a_emr: assert property (p_emr)
    else $error("extended mode load leaves dll off");
  a_lock: assert property (p_lock)
    else $error("read before dll lock time");
  a_rd_pre: assert property (p_rd_pre)
    else $error("precharge too soon after read");
  a_wr: assert property (p_wr)
    else $error("write strobe preamble wrong");
  a_post: assert property (p_post)
    else $error("too many refreshes postponed");
endmodule : dsp_ddr_props
`default_nettype wire

// >>> tb/test_ddr_sdram_powerup_and_read_bursts.sv
/*
  Bench: controller and memory joined by the link, power-up, writes, reads,
  idle refresh and self refresh. Assumes the controller makes the link clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_ddr_sdram_powerup_and_read_bursts;
  import dsp_pkg::*;
  localparam int PW = 20;
  localparam logic [63:0] DA = 64'h4444_3333_2222_1111;
  localparam logic [63:0] DB = 64'h8888_7777_6666_5555;
  localparam logic [63:0] DC = 64'hcccc_bbbb_aaaa_9999;
  logic clk, nrst, rd_req, wr_req, sref, ready, init_done;
  logic [1:0]  bank;
  logic [1:0]  rvalid;
  logic [12:0] row, mode, ref_row;
  logic [9:0]  col;
  logic [63:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  cmd;
  logic [7:0]  cmd_log[$];
  int err_count, n_checks, ar_cnt, pre_ck, nop_bad;
  dsp_ddr_if lnk();
  dsp_ddr_ctl #(.PWRUP_CYC(PW)) u_dsp_ddr_ctl (.CLK_IN(clk), .NRST_IN(nrst), .RD_REQ_IN(rd_req),
    .WR_REQ_IN(wr_req), .BANK_IN(bank), .ROW_IN(row), .COL_IN(col), .WDATA_IN(wdata), .SREF_IN(sref),
    .READY_OUT(ready), .INIT_DONE_OUT(init_done), .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .LNK(lnk));
  dsp_ddr_dev u_dsp_ddr_dev (.NRST_IN(nrst), .LNK(lnk), .MODE_OUT(mode), .REF_ROW_OUT(ref_row));
  dsp_ddr_props u_dsp_ddr_props (.ck(lnk.ck), .NRST_IN(nrst), .cke(lnk.cke), .cs_n(lnk.cs_n),
    .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba), .a(lnk.a),
    .dq_c_oe(lnk.dq_c_oe), .dqs_c_o(lnk.dqs_c_o), .dqs_c_oe(lnk.dqs_c_oe), .dq_d_oe(lnk.dq_d_oe),
    .dqs_d_o(lnk.dqs_d_o), .dqs_d_oe(lnk.dqs_d_oe));
  assign cmd = {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n};
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // power-up command log
  always @(posedge lnk.ck)
    if (nrst && !init_done)
    begin
      if (!lnk.cke) pre_ck++;
      if (!lnk.cke && cmd != C_NOP) nop_bad++;
      if (lnk.cke && cmd != C_NOP) cmd_log.push_back({cmd, lnk.ba, lnk.a[A_AP_BIT], lnk.a[MR_DLL_BIT]});
      if (lnk.cke && cmd == C_AR) ar_cnt++;
    end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!(ready === 1'b1 && init_done === 1'b1) && n < 4000);
    if (n >= 4000)
    begin
      check("ready", ready, 1'b1);
      conclude();
    end
  endtask : wait_ready
  task automatic req(input logic w, input logic [9:0] c, input logic [63:0] d);
    wait_ready();
    wr_req = w;
    rd_req = !w;
    bank = 2'h1;
    row = 13'h0a5;
    col = c;
    wdata = d;
    @(negedge clk);
    wr_req = 1'b0;
    rd_req = 1'b0;
  endtask : req
  function automatic logic [63:0] rot(input logic [63:0] d, input int s);
    for (int i = 0; i < 4; i++) rot[16*i +: 16] = d[16*((s + i) % 4) +: 16];
  endfunction : rot
  task automatic rd_check(input logic [9:0] c, input logic [63:0] exp);
    logic [63:0] got;
    int k, n;
    got = '0;
    k = 0;
    n = 0;
    req(1'b0, c, 64'h0);
    while (k < 4 && n < 1000)
    begin
      if (rvalid[0] === 1'b1)
      begin
        got[16*k +: 16] = rdata[15:0];
        k++;
      end
      if (rvalid[1] === 1'b1 && k < 4)
      begin
        got[16*k +: 16] = rdata[31:16];
        k++;
      end
      @(negedge clk);
      n++;
    end
    check("read burst", got, exp);
  endtask : rd_check
  ////////////////////////////////////////
  task automatic t_init;
    logic [7:0] ev[7] = '{{C_PRE, 4'h2}, {C_MRS, BA_EMR, 2'h0}, {C_MRS, BA_MR, 2'h1}, {C_PRE, 4'h2},
                          {C_AR, 4'h0}, {C_AR, 4'h0}, {C_MRS, BA_MR, 2'h0}};
    logic [7:0] mk[7] = '{8'hf2, 8'hfc, 8'hfd, 8'hf2, 8'hf0, 8'hf0, 8'hfd};
    wait_ready();
    check("init command count", 64'(cmd_log.size() >= 7), 1'b1);
    for (int i = 0; i < 7 && i < cmd_log.size(); i++) check("init command", cmd_log[i] & mk[i], ev[i]);
    check("stable clock before cke", 64'(pre_ck >= PW), 1'b1);
    check("no-op while cke low", nop_bad, 0);
    check("final mode", mode, MR_FINAL);
    check("refresh row count", ref_row, 13'(ar_cnt));
    $display("test init done");
  endtask : t_init
  task automatic t_rw;
    req(1'b1, 10'h000, DA);
    req(1'b1, 10'h004, DB);
    rd_check(10'h002, rot(DA, 2));
    rd_check(10'h005, rot(DB, 1));
    req(1'b1, 10'h006, DC);
    rd_check(10'h004, rot(DC, 2));
    rd_check(10'h000, rot(DA, 0));
    $display("test read write done");
  endtask : t_rw
  task automatic t_idle;
    logic [12:0] r0;
    r0 = ref_row;
    repeat (6000) @(negedge clk);
    check("refresh rows advance", 64'(ref_row - r0 >= 13'h003), 1'b1);
    $display("test idle refresh done");
  endtask : t_idle
  task automatic t_sref;
    int n;
    wait_ready();
    sref = 1'b1;
    n = 0;
    while (lnk.cke !== 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    check("cke in self refresh", lnk.cke, 1'b0);
    repeat (50) @(negedge clk);
    sref = 1'b0;
    rd_check(10'h001, rot(DA, 1));
    $display("test self refresh done");
  endtask : t_sref
  initial
  begin
    {rd_req, wr_req, sref, bank, row, col, wdata} = '0;
    nrst = 1'b1;
    #1 nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    t_init();
    t_rw();
    t_idle();
    t_sref();
    conclude();
  end
endmodule : test_ddr_sdram_powerup_and_read_bursts
`default_nettype wire
